// [hw/charge_cycle_sequencer.sv]
// charge_cycle_sequencer: phase sequencer of a single-cell charger
// assumes comparator inputs come from the analog front end, any clock
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps

// Notes on behaviour
// - start pre-qualification only with supply in window and adaptor ok
// - pre-qualification drives a small current below 70 mA
// - battery above 3.0 V moves pre-qualification to constant current
// - adaptor source charges at 500 mA default, software may change it
// - usb source with select high starts constant current at 100 mA
// - safety timer of 5.6 hr starts on entry to constant current
// - timer expiry while in constant current ends charging
// - regulation target 4.2 V or 4.1 V moves to constant voltage
// - current below end-of-charge threshold raises end-of-charge
// - threshold selects 0.1C, 0.15C or 0.2C, 0.1C after reset
// - after completion the maintenance phase watches pack voltage
// - pack 200 mV under termination with valid source restarts charge
// - temperature out of range stops charging in every phase
// - power-up loads default current, regulation and threshold
// - usb charges 100 mA with select high, the programmed current (500 mA default) when driven low
// - temperature recovery restarts from first phase, timer reset
// - timer fault or temperature fault lights both status outputs
// - enable switches the charger, treated high unless driven low
module charge_cycle_sequencer #(
  parameter int unsigned PRESCALE_CYCLES = charge_seq_pkg::PRESCALE_CYCLES,
  parameter int unsigned SAFETY_TICKS    = charge_seq_pkg::SAFETY_TICKS
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  input  wire charge_seq_pkg::sense_t sense_in,
  input  wire logic                   source_is_adaptor,
  input  wire logic                   current_select_pin,
  input  wire logic                   enable_pin,
  output logic      [9:0]             charge_current,
  output logic                        constant_voltage,
  output logic                        battery_regulated_voltage_low,
  output logic      [1:0]             eoc_threshold_sel,
  output logic                        charging_indicator_out,
  output logic                        charging_indicator_oe,
  output logic                        eoc_indicator_out,
  output logic                        eoc_indicator_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // functions
  function automatic logic [9:0] code_to_ma(input logic [3:0] code);
    logic [3:0] c;
    c = (code > charge_seq_pkg::CODE_MAX) ? charge_seq_pkg::CODE_MAX : code;
    code_to_ma = charge_seq_pkg::CODE_BASE_MA +
                 10'(charge_seq_pkg::CODE_STEP_MA * c);
  endfunction : code_to_ma

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  charge_seq_pkg::sense_t sense_s1_r;
  charge_seq_pkg::sense_t sense_r;
  logic [2:0]             pins_s1_r;
  logic [2:0]             pins_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sense_s1_r <= '0;
      sense_r    <= '0;
      pins_s1_r  <= 3'h3;
      pins_r     <= 3'h3;
    end else begin
      sense_s1_r <= sense_in;
      sense_r    <= sense_s1_r;
      pins_s1_r  <= {source_is_adaptor, current_select_pin, enable_pin};
      pins_r     <= pins_s1_r;
    end
  end

  logic adaptor_s;
  logic sel_s;
  logic en_s;
  logic src_ok;
  assign adaptor_s = pins_r[2];
  assign sel_s     = pins_r[1];
  assign en_s      = pins_r[0];
  assign src_ok    = sense_r.uv_ok & sense_r.ov_ok & sense_r.adaptor_ok;

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  charge_seq_pkg::ctrl_t ctrl_r;
  charge_seq_pkg::ctrl_t ctrl_nxt;
  logic [31:0]           rdata_r;
  logic [31:0]           rdata_nxt;
  logic                  wait_r;
  logic                  wait_nxt;
  charge_seq_pkg::phase_t phase_r;
  charge_seq_pkg::phase_t phase_nxt;
  logic [charge_seq_pkg::TIMER_W-1:0]    tick_cnt_r;
  logic [charge_seq_pkg::TIMER_W-1:0]    tick_cnt_nxt;
  logic [charge_seq_pkg::PRESCALE_W-1:0] pre_cnt_r;
  logic [charge_seq_pkg::PRESCALE_W-1:0] pre_cnt_nxt;
  logic                  expired_r;
  logic                  expired_nxt;
  logic                  passed_maint_r;
  logic                  passed_maint_nxt;

  always_comb begin
    ctrl_nxt  = ctrl_r;
    rdata_nxt = rdata_r;
    wait_nxt  = !((avs_read || avs_write) && wait_r);
    if (avs_write && !wait_r && avs_address == charge_seq_pkg::ADDR_CTRL &&
        avs_byteenable[0]) begin
      ctrl_nxt.cur_code =
        avs_writedata[charge_seq_pkg::CUR_MSB:charge_seq_pkg::CUR_LSB];
      ctrl_nxt.eoc_sel =
        avs_writedata[charge_seq_pkg::EOC_MSB:charge_seq_pkg::EOC_LSB];
      ctrl_nxt.vreg_low = avs_writedata[charge_seq_pkg::VREG_BIT];
    end
    if (avs_read && wait_r) begin
      case (avs_address)
        charge_seq_pkg::ADDR_CTRL:   rdata_nxt = {25'h0, ctrl_r};
        charge_seq_pkg::ADDR_STATUS:
          rdata_nxt = {13'h0, expired_r, passed_maint_r, en_s, src_ok,
                       sense_r, phase_r};
        charge_seq_pkg::ADDR_TIMER:  rdata_nxt = {7'h0, tick_cnt_r};
        default:                     rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r <= {charge_seq_pkg::VREG_RESET, charge_seq_pkg::EOC_RESET,
                 charge_seq_pkg::CUR_RESET};
      rdata_r <= 32'h0000_0000;
      wait_r  <= 1'b1;
    end else begin
      ctrl_r  <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      wait_r  <= wait_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencer
  logic run_ok;
  assign run_ok = src_ok && en_s;

  always_comb begin
    phase_nxt        = phase_r;
    passed_maint_nxt = passed_maint_r;
    if (!run_ok) begin
      phase_nxt        = charge_seq_pkg::PH_OFF;
      passed_maint_nxt = 1'b0;
    end else if (!sense_r.temp_ok) begin
      phase_nxt = charge_seq_pkg::PH_TEMP;
    end else begin
      case (phase_r)
        charge_seq_pkg::PH_OFF: begin
          phase_nxt = charge_seq_pkg::PH_PREQUAL;
        end
        charge_seq_pkg::PH_PREQUAL: begin
          if (sense_r.battery_terminal_above_prequal) begin
            phase_nxt = charge_seq_pkg::PH_CC;
          end
        end
        charge_seq_pkg::PH_CC: begin
          if (expired_r) begin
            phase_nxt = charge_seq_pkg::PH_TIMEOUT;
          end else if (sense_r.battery_terminal_at_regulation) begin
            phase_nxt = charge_seq_pkg::PH_CV;
          end
        end
        charge_seq_pkg::PH_CV: begin
          if (sense_r.current_below_eoc) begin
            phase_nxt = charge_seq_pkg::PH_MAINT;
          end
        end
        charge_seq_pkg::PH_MAINT: begin
          if (sense_r.battery_terminal_below_restart) begin
            phase_nxt        = charge_seq_pkg::PH_PREQUAL;
            passed_maint_nxt = 1'b1;
          end
        end
        charge_seq_pkg::PH_TIMEOUT: begin
          phase_nxt = charge_seq_pkg::PH_TIMEOUT;
        end
        charge_seq_pkg::PH_TEMP: begin
          phase_nxt = charge_seq_pkg::PH_PREQUAL;
        end
        default: begin
          phase_nxt = charge_seq_pkg::PH_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // safety timer
  always_comb begin
    pre_cnt_nxt  = pre_cnt_r;
    tick_cnt_nxt = tick_cnt_r;
    expired_nxt  = expired_r;
    if (phase_r != charge_seq_pkg::PH_CC &&
        phase_nxt == charge_seq_pkg::PH_CC) begin
      pre_cnt_nxt  = '0;
      tick_cnt_nxt = '0;
      expired_nxt  = 1'b0;
    end else if (phase_nxt == charge_seq_pkg::PH_PREQUAL ||
                 phase_nxt == charge_seq_pkg::PH_OFF) begin
      pre_cnt_nxt  = '0;
      tick_cnt_nxt = '0;
      expired_nxt  = 1'b0;
    end else if (phase_r == charge_seq_pkg::PH_CC && !expired_r) begin
      if (pre_cnt_r ==
          charge_seq_pkg::PRESCALE_W'(PRESCALE_CYCLES - 1)) begin
        pre_cnt_nxt  = '0;
        tick_cnt_nxt = tick_cnt_r + 1'b1;
        if (tick_cnt_r ==
            charge_seq_pkg::TIMER_W'(SAFETY_TICKS - 1)) begin
          expired_nxt = 1'b1;
        end
      end else begin
        pre_cnt_nxt = pre_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_r        <= charge_seq_pkg::PH_OFF;
      passed_maint_r <= 1'b0;
      pre_cnt_r      <= '0;
      tick_cnt_r     <= '0;
      expired_r      <= 1'b0;
    end else begin
      phase_r        <= phase_nxt;
      passed_maint_r <= passed_maint_nxt;
      pre_cnt_r      <= pre_cnt_nxt;
      tick_cnt_r     <= tick_cnt_nxt;
      expired_r      <= expired_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current request and indicators
  logic [9:0] cc_ma;
  logic [9:0] cur_nxt;
  logic       chg_on_nxt;
  logic       eoc_on_nxt;

  always_comb begin
    if (adaptor_s || !sel_s) begin
      cc_ma = code_to_ma(ctrl_r.cur_code);
    end else begin
      cc_ma = charge_seq_pkg::USB_LOW_MA;
    end
    cur_nxt    = charge_seq_pkg::OFF_MA;
    chg_on_nxt = 1'b0;
    eoc_on_nxt = 1'b0;
    case (phase_r)
      charge_seq_pkg::PH_OFF: begin
        eoc_on_nxt = src_ok && !en_s;
      end
      charge_seq_pkg::PH_PREQUAL: begin
        cur_nxt    = charge_seq_pkg::PREQUAL_MA;
        chg_on_nxt = !passed_maint_r;
        eoc_on_nxt = passed_maint_r;
      end
      charge_seq_pkg::PH_CC, charge_seq_pkg::PH_CV: begin
        cur_nxt    = cc_ma;
        chg_on_nxt = !passed_maint_r;
        eoc_on_nxt = passed_maint_r;
      end
      charge_seq_pkg::PH_MAINT: begin
        eoc_on_nxt = 1'b1;
      end
      charge_seq_pkg::PH_TIMEOUT, charge_seq_pkg::PH_TEMP: begin
        chg_on_nxt = 1'b1;
        eoc_on_nxt = 1'b1;
      end
      default: begin
        cur_nxt = charge_seq_pkg::OFF_MA;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      charge_current                <= charge_seq_pkg::OFF_MA;
      constant_voltage              <= 1'b0;
      battery_regulated_voltage_low <= charge_seq_pkg::VREG_RESET;
      eoc_threshold_sel             <= charge_seq_pkg::EOC_RESET;
      charging_indicator_out        <= 1'b0;
      charging_indicator_oe         <= 1'b0;
      eoc_indicator_out             <= 1'b0;
      eoc_indicator_oe              <= 1'b0;
      avs_readdata                  <= 32'h0000_0000;
      avs_waitrequest               <= 1'b1;
    end else begin
      charge_current   <= cur_nxt;
      constant_voltage <= (phase_r == charge_seq_pkg::PH_CV);
      battery_regulated_voltage_low <= ctrl_r.vreg_low;
      eoc_threshold_sel      <= ctrl_r.eoc_sel;
      charging_indicator_out <= 1'b0;
      charging_indicator_oe  <= chg_on_nxt;
      eoc_indicator_out      <= 1'b0;
      eoc_indicator_oe       <= eoc_on_nxt;
      avs_readdata           <= rdata_nxt;
      avs_waitrequest        <= wait_nxt;
    end
  end

endmodule : charge_cycle_sequencer

// [hw/charge_seq_pkg.sv]
// charge_seq_pkg: constants, register map and types of the charge sequencer
// assumes a 50 MHz system clock and a 32-bit Avalon-MM register port
package charge_seq_pkg;

  //////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_MHZ            = 50;
  localparam int unsigned TICK_US            = 1000;
  localparam int unsigned PRESCALE_CYCLES    = TICK_US * CLK_MHZ;
  localparam int unsigned SAFETY_TENTHS_HR   = 56;
  localparam int unsigned TICKS_PER_TENTH_HR = 360000;
  localparam int unsigned SAFETY_TICKS       =
    SAFETY_TENTHS_HR * TICKS_PER_TENTH_HR;
  localparam int unsigned PRESCALE_W         = 16;
  localparam int unsigned TIMER_W            = 25;

  //////////////////////////////////////////////////////////////////////////
  // charge currents in mA
  localparam logic [9:0] PREQUAL_MA   = 10'h032;
  localparam logic [9:0] USB_LOW_MA   = 10'h064;
  localparam logic [9:0] CODE_BASE_MA = 10'h064;
  localparam logic [9:0] CODE_STEP_MA = 10'h032;
  localparam logic [9:0] OFF_MA       = 10'h000;
  localparam logic [3:0] CODE_MAX     = 4'hD;

  //////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_TIMER  = 4'h8;

  // control fields, all in byte 0
  localparam int unsigned CUR_LSB  = 0;
  localparam int unsigned CUR_MSB  = 3;
  localparam int unsigned EOC_LSB  = 4;
  localparam int unsigned EOC_MSB  = 5;
  localparam int unsigned VREG_BIT = 6;

  // reset values
  localparam logic [3:0] CUR_RESET  = 4'h8;
  localparam logic [1:0] EOC_RESET  = 2'h0;
  localparam logic       VREG_RESET = 1'b0;

  // end-of-charge threshold selections
  localparam logic [1:0] EOC_0P10C = 2'h0;
  localparam logic [1:0] EOC_0P15C = 2'h1;
  localparam logic [1:0] EOC_0P20C = 2'h2;

  //////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [6:0] {
    PH_OFF     = 7'h01,
    PH_PREQUAL = 7'h02,
    PH_CC      = 7'h04,
    PH_CV      = 7'h08,
    PH_MAINT   = 7'h10,
    PH_TIMEOUT = 7'h20,
    PH_TEMP    = 7'h40
  } phase_t;

  typedef struct packed {
    logic uv_ok;
    logic ov_ok;
    logic adaptor_ok;
    logic temp_ok;
    logic battery_terminal_above_prequal;
    logic battery_terminal_at_regulation;
    logic battery_terminal_below_restart;
    logic current_below_eoc;
  } sense_t;

  typedef struct packed {
    logic       vreg_low;
    logic [1:0] eoc_sel;
    logic [3:0] cur_code;
  } ctrl_t;

endpackage : charge_seq_pkg

// [test/battery_source_model.sv]
// battery_source_model: pack and source comparators seen by the sequencer
// assumes the bench sets supply, pack voltage, taper current and temperature
`timescale 1ns/1ps
module battery_source_model #(
  parameter int unsigned CAP_MA = 500,
  parameter int unsigned UV_MV  = 4000,
  parameter int unsigned OV_MV  = 6500
) (
  input  wire logic         sys_clk,
  input  wire logic [12:0]  supply_mv,
  input  wire logic         adaptor_good,
  input  wire logic         temp_good,
  input  wire logic [12:0]  battery_terminal_mv,
  input  wire logic [9:0]   taper_ma,
  input  wire logic [9:0]   charge_current,
  input  wire logic         constant_voltage,
  input  wire logic         vreg_low,
  input  wire logic [1:0]   eoc_sel,
  output charge_seq_pkg::sense_t sense_in
);
  logic [12:0] term_mv;
  logic [9:0]  eoc_ma;
  always_comb begin
    term_mv = vreg_low ? 13'h1004 : 13'h1068; // 4.1 V or 4.2 V
    case (eoc_sel)
      charge_seq_pkg::EOC_0P15C: eoc_ma = 10'(CAP_MA * 15 / 100);
      charge_seq_pkg::EOC_0P20C: eoc_ma = 10'(CAP_MA / 5);
      default:                   eoc_ma = 10'(CAP_MA / 10);
    endcase
  end
  always_ff @(posedge sys_clk) begin
    sense_in.uv_ok              <= supply_mv >= 13'(UV_MV);
    sense_in.ov_ok              <= supply_mv <= 13'(OV_MV);
    sense_in.adaptor_ok         <= adaptor_good;
    sense_in.temp_ok            <= temp_good;
    sense_in.battery_terminal_above_prequal <= battery_terminal_mv > 13'hBB8;
    sense_in.battery_terminal_at_regulation <= battery_terminal_mv >= term_mv;
    sense_in.battery_terminal_below_restart <= battery_terminal_mv < term_mv - 13'h0C8;
    sense_in.current_below_eoc  <= (constant_voltage ? taper_ma :
                                    charge_current) < eoc_ma;
  end
endmodule : battery_source_model

// [test/charge_cycle_sequencer_test.sv]
// charge_cycle_sequencer_test: directed run through the charge phases
// assumes the design, its package, the checker and the pack model
`timescale 1ns/1ps
module charge_cycle_sequencer_test;
  logic                   sys_clk, rst_n, avs_read, avs_write, eoc_oe;
  logic [3:0]             avs_address, avs_byteenable;
  logic [31:0]            avs_writedata, avs_readdata, q;
  logic                   avs_waitrequest, source_is_adaptor, chg_oe;
  logic                   current_select_pin, enable_pin, constant_voltage;
  logic                   vreg_low, adaptor_good, temp_good;
  logic [9:0]             charge_current, taper_ma;
  logic [1:0]             eoc_sel;
  logic [12:0]            supply_mv, battery_terminal_mv;
  charge_seq_pkg::sense_t sense_in;
  int                     num_errors, n_compared;

  charge_cycle_sequencer #(.PRESCALE_CYCLES(4), .SAFETY_TICKS(20))
  charge_cycle_sequencer_i (.sys_clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .sense_in, .source_is_adaptor, .current_select_pin,
    .enable_pin, .charge_current, .constant_voltage,
    .battery_regulated_voltage_low(vreg_low), .eoc_threshold_sel(eoc_sel),
    .charging_indicator_out(), .charging_indicator_oe(chg_oe),
    .eoc_indicator_out(), .eoc_indicator_oe(eoc_oe));
  battery_source_model battery_source_model_i (.sys_clk, .supply_mv,
    .adaptor_good, .temp_good, .battery_terminal_mv, .taper_ma, .charge_current,
    .constant_voltage, .vreg_low, .eoc_sel, .sense_in);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_address   <= a;
    avs_writedata <= d;
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  task automatic st(input charge_seq_pkg::phase_t p);
    bus(1'b0, charge_seq_pkg::ADDR_STATUS, 32'h0);
    chk(32'(q[6:0]), 32'(p));
  endtask : st
  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  //////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    wt(5000);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    rst_n              <= 1'b0;
    avs_read           <= 1'b0;
    avs_write          <= 1'b0;
    avs_address        <= 4'h0;
    avs_writedata      <= 32'h0;
    avs_byteenable     <= 4'hF;
    source_is_adaptor  <= 1'b1;
    current_select_pin <= 1'b1;
    enable_pin         <= 1'b1;
    supply_mv          <= 13'h1388;
    adaptor_good       <= 1'b0;
    temp_good          <= 1'b1;
    battery_terminal_mv            <= 13'hAF0;
    taper_ma           <= 10'h03C;
    wt(5);
    rst_n <= 1'b1;
    bus(1'b0, charge_seq_pkg::ADDR_CTRL, 32'h0);
    chk(q, 32'h8);
    chk(32'({vreg_low, eoc_sel}), 32'h0);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    wt(8);
    st(charge_seq_pkg::PH_OFF);
    adaptor_good <= 1'b1;
    supply_mv    <= 13'h1B58;
    wt(8);
    chk(32'(charge_current), 32'h0);
    supply_mv <= 13'h1388;
    wt(8);
    chk(32'(charge_current), 32'h32);
    chk(32'({chg_oe, eoc_oe}), 32'h2);
    battery_terminal_mv <= 13'hDAC;
    wt(8);
    st(charge_seq_pkg::PH_CC);
    chk(32'(charge_current), 32'h1F4);
    bus(1'b0, charge_seq_pkg::ADDR_TIMER, 32'h0);
    chk(32'(q != 32'h0), 32'h1);
    bus(1'b1, charge_seq_pkg::ADDR_CTRL, 32'h2);
    wt(3);
    chk(32'(charge_current), 32'hC8);
    battery_terminal_mv <= 13'h1068;
    wt(8);
    chk(32'(constant_voltage), 32'h1);
    st(charge_seq_pkg::PH_CV);
    bus(1'b1, charge_seq_pkg::ADDR_CTRL, 32'h22);
    wt(8);
    st(charge_seq_pkg::PH_MAINT);
    chk(32'({chg_oe, eoc_oe}), 32'h1);
    battery_terminal_mv <= 13'hAF0;
    wt(8);
    st(charge_seq_pkg::PH_PREQUAL);
    temp_good <= 1'b0;
    wt(8);
    chk(32'(charge_current), 32'h0);
    chk(32'({chg_oe, eoc_oe}), 32'h3);
    temp_good <= 1'b1;
    wt(8);
    st(charge_seq_pkg::PH_PREQUAL);
    bus(1'b0, charge_seq_pkg::ADDR_TIMER, 32'h0);
    chk(q, 32'h0);
    battery_terminal_mv <= 13'hDAC;
    wt(110);
    st(charge_seq_pkg::PH_TIMEOUT);
    chk(32'({chg_oe, eoc_oe, charge_current}), 32'hC00);
    enable_pin <= 1'b0;
    wt(8);
    chk(32'({chg_oe, eoc_oe, charge_current}), 32'h400);
    enable_pin        <= 1'b1;
    source_is_adaptor <= 1'b0;
    bus(1'b1, charge_seq_pkg::ADDR_CTRL, 32'h8);
    wt(8);
    chk(32'(charge_current), 32'h64);
    current_select_pin <= 1'b0; // usb controller asks more
    wt(8);
    chk(32'(charge_current), 32'h1F4);
    bus(1'b1, charge_seq_pkg::ADDR_CTRL, 32'h48);
    wt(3);
    chk(32'(vreg_low), 32'h1);
    battery_terminal_mv <= 13'h1036;
    wt(8);
    chk(32'(constant_voltage), 32'h1);
    bus(1'b1, charge_seq_pkg::ADDR_CTRL, 32'h4F);
    wt(3);
    chk(32'(charge_current), 32'h2EE);
    bus(1'b1, charge_seq_pkg::ADDR_CTRL, 32'h5F);
    wt(8);
    st(charge_seq_pkg::PH_MAINT);
    chk(32'(eoc_sel), 32'h1);
    chk(32'({chg_oe, eoc_oe, charge_current}), 32'h400);
    supply_mv <= 13'h0;
    wt(8);
    chk(32'({chg_oe, eoc_oe, charge_current}), 32'h0);
    tally_and_finish();
  end
endmodule : charge_cycle_sequencer_test

// [test/charge_seq_props.sv]
// charge_seq_props: port checks of the charge sequencer
// assumes it is bound onto charge_cycle_sequencer, one clock
`timescale 1ns/1ps
module charge_seq_props #(
  parameter int unsigned PRESCALE_CYCLES = 4,
  parameter int unsigned SAFETY_TICKS    = 20
) (
  input wire logic                   sys_clk,
  input wire logic                   rst_n,
  input wire logic [3:0]             avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire charge_seq_pkg::sense_t sense_in,
  input wire logic                   enable_pin,
  input wire logic [9:0]             charge_current,
  input wire logic                   battery_regulated_voltage_low,
  input wire logic [1:0]             eoc_threshold_sel,
  input wire logic                   charging_indicator_out,
  input wire logic                   charging_indicator_oe,
  input wire logic                   eoc_indicator_out,
  input wire logic                   eoc_indicator_oe
);
  wire logic [2:0] wr_sel = avs_writedata[6:4];
  wire logic       src_ok = sense_in.uv_ok && sense_in.ov_ok &&
                            sense_in.adaptor_ok;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////
  sequence s_taken; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ctrl_wr;
    avs_write && !avs_waitrequest && avs_byteenable[0] &&
    avs_address == charge_seq_pkg::ADDR_CTRL;
  endsequence
  sequence s_hot; (src_ok && enable_pin && !sense_in.temp_ok) [*5]; endsequence
  sequence s_off; (src_ok && !enable_pin) [*5]; endsequence
  a_wait_low: assert property (s_taken |=> !avs_waitrequest)
    else $error("waitrequest stayed high");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_unmapped_zero: assert property (s_taken ##0 (avs_read && !(avs_address
    inside {4'h0, 4'h4, 4'h8})) |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_follow: assert property (s_ctrl_wr |-> ##2
    {battery_regulated_voltage_low, eoc_threshold_sel} == $past(wr_sel, 2))
    else $error("selection outputs do not follow control");
  a_reset_defaults: assert property (
    @(posedge sys_clk) disable iff (1'b0) !rst_n |=>
    charge_current == charge_seq_pkg::OFF_MA && avs_waitrequest &&
    !charging_indicator_oe && eoc_threshold_sel == charge_seq_pkg::EOC_RESET
    && battery_regulated_voltage_low == charge_seq_pkg::VREG_RESET)
    else $error("reset values wrong");
  a_temp_stop: assert property (
    s_hot |=> charge_current == 10'h000)
    else $error("charging during temperature fault");
  a_fault_leds: assert property (
    s_hot |=> charging_indicator_oe && eoc_indicator_oe)
    else $error("fault leds not both on");
  a_disable_off: assert property (
    s_off |=> charge_current == 10'h000 &&
    !charging_indicator_oe && eoc_indicator_oe)
    else $error("disabled charger not idle");
  a_no_supply: assert property ((!sense_in.uv_ok) [*5] |=>
    charge_current == 10'h000 && !charging_indicator_oe && !eoc_indicator_oe)
    else $error("activity without supply");
  a_cur_legal: assert property (charge_current <= 10'h2EE &&
    charge_current % 50 == 0) else $error("illegal charge current");
  a_open_drain: assert property (!charging_indicator_out &&
    !eoc_indicator_out) else $error("open drain value high");
endmodule : charge_seq_props

bind charge_cycle_sequencer charge_seq_props #(
  .PRESCALE_CYCLES(PRESCALE_CYCLES), .SAFETY_TICKS(SAFETY_TICKS)
) charge_seq_props_i (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .sense_in, .enable_pin, .charge_current, .battery_regulated_voltage_low,
  .eoc_threshold_sel, .charging_indicator_out, .charging_indicator_oe,
  .eoc_indicator_out, .eoc_indicator_oe);
